// ### verif/serial_flash_command_decoder_tb.sv
// Self-checking bench for the command decoder, one task per scenario.
// Assumes the host model drives the pins and the bench plays the engine side.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_command_decoder_tb;
   import sfcd_pkg::*;
   logic        clk, rst_n, sclk, cs_n, si, so, so_oe, busy, op_done, req, go, dv, wp;
   logic [5:0]  prot;
   logic [7:0]  arr, dat;
   logic [23:0] addr;
   sfcd_cmd_t   cmd, last_cmd;
   wire logic   so_line = so_oe ? so : 1'bz;
   int          n_fail, tests_run, n_go, n_req, n_dv;
   logic        oe_seen;
   logic [7:0]  rxq[$];

   sfcd_top u_sfcd_top (.i_core_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
      .o_so(so), .o_so_oe(so_oe), .i_busy(busy), .i_op_done(op_done), .i_prot_bits(prot),
      .i_array_byte(arr), .o_array_req(req), .o_cmd_go(go), .o_cmd(cmd), .o_addr(addr),
      .o_data_valid(dv), .o_data(dat), .o_write_permit(wp));
   sfcd_host_model u_sfcd_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));

   // 125 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Commit and streaming observer
   always @(posedge clk)
   begin
      if (go === 1'b1)
      begin
         n_go++;
         last_cmd = cmd;
      end
      if (so_oe === 1'b1)
         oe_seen = 1'b1;
      if (req === 1'b1)
         n_req++;
      if (dv === 1'b1)
         n_dv++;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Frame plus settle time for the commit to land
   task automatic run(input logic [7:0] tx[$], input int extra, input int nrx, input bit m3);
      n_go = 0;
      oe_seen = 1'b0;
      n_req = 0;
      n_dv = 0;
      u_sfcd_host_model.frame(tx, extra, nrx, m3, rxq);
      repeat (10) @(posedge clk);
      #1;
   endtask

   task automatic t_permit();
      chk(wp, 1'b0);
      chk(24'(cmd), 24'(CMD_NONE));
      run('{OP_PERMIT_SET}, 3, 0, 0);
      chk(n_go, 0);
      chk(wp, 1'b0);
      run('{OP_PERMIT_SET}, 0, 0, 1);
      chk(24'(last_cmd), 24'(CMD_PERMIT_SET));
      chk(wp, 1'b1);
      run('{OP_PERMIT_CLR}, 0, 0, 0);
      chk(wp, 1'b0);
   endtask

   // Every modifying opcode: refused without permit, then done with it
   task automatic t_modify();
      logic [7:0] ops[7] = '{OP_STATE_WR, OP_PAGE_WRITE, OP_SMALL_CLR, OP_LARGE_CLR_A, OP_LARGE_CLR_B,
                             OP_WHOLE_CLR_A, OP_WHOLE_CLR_B};
      int         len[7] = '{2, 5, 4, 4, 4, 1, 1};
      sfcd_cmd_t  exp[7] = '{CMD_STATE_WR, CMD_PAGE_WRITE, CMD_SMALL_CLR, CMD_LARGE_CLR, CMD_LARGE_CLR,
                             CMD_WHOLE_CLR, CMD_WHOLE_CLR};
      logic [7:0] tx[$];
      for (int i = 0; i < 7; i++)
      begin
         tx = '{ops[i], 8'h12, 8'h34, 8'h56, 8'h78};
         tx = tx[0:len[i]-1];
         run(tx, 0, 0, 0);
         chk(n_go, 0);
         run('{OP_PERMIT_SET}, 0, 0, 0);
         run(tx, 0, 0, i[0]);
         chk(n_go, 1);
         chk(24'(last_cmd), 24'(exp[i]));
         chk(n_dv, (len[i] == 2 || len[i] == 5) ? 1 : 0);
         if (len[i] == 2 || len[i] == 5)
            chk(dat, tx[len[i]-1]);
         if (len[i] >= 4)
            chk(addr, 24'h123456);
         chk(wp, 1'b1);
         @(posedge clk);
         #1 op_done = 1'b1;
         @(posedge clk);
         #1 op_done = 1'b0;
         @(posedge clk);
         #1 chk(wp, 1'b0);
      end
      run('{OP_PERMIT_SET}, 0, 0, 0);
      run('{OP_PAGE_WRITE, 8'h00, 8'h00, 8'h00, 8'h00}, 5, 0, 0);
      chk(n_go, 0);
   endtask

   // Status stream while busy, repeated
   task automatic t_status();
      prot = 6'h2A;
      busy = 1'b1;
      run('{OP_STATE_RD}, 0, 2, 1);
      chk(rxq[0], 8'hAB);
      chk(rxq[1], 8'hAB);
      busy = 1'b0;
      run('{OP_STATE_RD}, 0, 1, 0);
      chk(rxq[0], 8'hAA);
   endtask

   task automatic t_ident();
      run('{OP_MAKER_PART, 8'hFF, 8'hFF, ORDER_MAKER_FIRST}, 0, 2, 0);
      chk({rxq[0], rxq[1]}, 16'h5C12);
      run('{OP_MAKER_PART, 8'h00, 8'h00, ORDER_PART_FIRST}, 0, 2, 1);
      chk({rxq[0], rxq[1]}, 16'h125C);
      run('{OP_ID_TRIPLE}, 0, 3, 0);
      chk({rxq[0], rxq[1], rxq[2]}, 24'h5C2112);
      run('{OP_LEGACY_ID, 8'h00, 8'h00, 8'h00}, 0, 1, 0);
      chk(rxq[0], 8'h11);
      run('{OP_SLEEP_ENTRY}, 0, 0, 0);
      chk(24'(last_cmd), 24'(CMD_SLEEP_ENTRY));
      run('{OP_LEGACY_ID}, 0, 0, 0);
      chk(24'(last_cmd), 24'(CMD_SLEEP_EXIT));
   endtask

   // Read family header lengths, then an undefined opcode
   task automatic t_reads();
      logic [7:0] ops[4] = '{OP_READ, OP_FAST_READ, OP_READ_TWO, OP_PARAM_READ};
      logic [7:0] tx[$];
      arr = 8'h3C;
      for (int i = 0; i < 4; i++)
      begin
         tx = '{ops[i], 8'h00, 8'h00, 8'h00};
         if (i > 0)
            tx.push_back(8'h00);
         run(tx, 0, 1, 0);
         chk(rxq[0], 8'h3C);
         chk(n_req, 2);
      end
      run('{8'hFF, 8'h00}, 0, 1, 0);
      chk(oe_seen, 1'b0);
      chk(n_go, 0);
   endtask

   // Mid-run reset drops a set latch; decoder answers cleanly afterwards
   task automatic t_reset();
      chk(wp, 1'b1);
      rst_n = 1'b0;
      @(posedge clk);
      #1 chk(wp, 1'b0);
      repeat (9) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1 chk(wp, 1'b0);
      run('{OP_STATE_RD}, 0, 1, 1);
      chk(rxq[0], 8'hA8);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial
   begin
      #600000;
      n_fail++;
      final_report();
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      busy = 1'b0;
      op_done = 1'b0;
      prot = 6'h00;
      arr = 8'h00;
      n_fail = 0;
      tests_run = 0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      t_permit();
      t_modify();
      t_status();
      t_ident();
      t_reads();
      t_reset();
      final_report();
   end
endmodule // serial_flash_command_decoder_tb
`default_nettype wire

// ### verif/sfcd_host_model.sv
// Host-side SPI master model: frames, shifts bytes out MSB first, captures replies.
// Assumes the bench ties its pins to the decoder pins; modes 0 and 3 only.
`timescale 1ns/10ps
`default_nettype none
module sfcd_host_model
#(
   parameter realtime HALF = 62.5
)
(
   // Serial pins towards the device
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_si,
   // Device answer line
   input  wire logic i_so
);
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si   = 1'b1;
   end

   // One bit: data set while clock low, reply sampled at the rise
   task automatic put_bit(input logic v, output logic s);
      o_sclk = 1'b0;
      o_si   = v;
      #HALF;
      o_sclk = 1'b1;
      s      = i_so;
      #HALF;
   endtask

   // Whole frame; clock stands still outside it, idle data line toggles
   task automatic frame(input logic [7:0] tx[$], input int extra, input int nrx, input bit mode3,
                        output logic [7:0] rx[$]);
      logic [7:0] b;
      logic       s;
      rx = {};
      o_sclk = mode3;
      #HALF;
      o_cs_n = 1'b0;
      #HALF;
      for (int i = 0; i < tx.size() + nrx; i++)
      begin
         b = (i < tx.size()) ? tx[i] : 8'h00;
         for (int k = 7; k >= 0; k--)
         begin
            put_bit(b[k], s);
            if (i >= tx.size())
               b[k] = s;
         end
         if (i >= tx.size())
            rx.push_back(b);
      end
      for (int k = 0; k < extra; k++)
         put_bit(1'b0, s);
      if (!mode3)
         o_sclk = 1'b0;
      #HALF;
      o_cs_n = 1'b1;
      o_si   = ~o_si;
      #(4 * HALF);
   endtask
endmodule // sfcd_host_model
`default_nettype wire

// ### verilog/sfcd_link_if.sv
// Interface carrying the synchronised serial pins to the decoder core.
// Assumes the driving side already passed every pin through two flip-flops.
`timescale 1ns/10ps
`default_nettype none
interface sfcd_link_if;
   logic sclk;
   logic cs_n;
   logic si;

   modport drive (output sclk, output cs_n, output si);
   modport core  (input sclk, input cs_n, input si);
endinterface
`default_nettype wire

// ### verilog/sfcd_pkg.sv
// Package for the serial flash command decoder: opcodes, command kinds,
// header lengths and decoder states.
// Assumes SPI modes 0 and 3, with the opcode sent most significant bit first.
package sfcd_pkg;

   // Opcodes of the defined command set
   localparam logic [7:0] OP_PERMIT_SET   = 8'h06;
   localparam logic [7:0] OP_PERMIT_CLR   = 8'h04;
   localparam logic [7:0] OP_STATE_WR     = 8'h01;
   localparam logic [7:0] OP_STATE_RD     = 8'h05;
   localparam logic [7:0] OP_ID_TRIPLE    = 8'h9F;
   localparam logic [7:0] OP_READ         = 8'h03;
   localparam logic [7:0] OP_FAST_READ    = 8'h0B;
   localparam logic [7:0] OP_READ_TWO     = 8'h3B;
   localparam logic [7:0] OP_PARAM_READ   = 8'h5A;
   localparam logic [7:0] OP_LEGACY_ID    = 8'hAB;
   localparam logic [7:0] OP_MAKER_PART   = 8'h90;
   localparam logic [7:0] OP_SMALL_CLR    = 8'h20;
   localparam logic [7:0] OP_LARGE_CLR_A  = 8'h52;
   localparam logic [7:0] OP_LARGE_CLR_B  = 8'hD8;
   localparam logic [7:0] OP_WHOLE_CLR_A  = 8'h60;
   localparam logic [7:0] OP_WHOLE_CLR_B  = 8'hC7;
   localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
   localparam logic [7:0] OP_SLEEP_ENTRY  = 8'hB9;

   // Order-select values of the maker/part query
   localparam logic [7:0] ORDER_MAKER_FIRST = 8'h00;
   localparam logic [7:0] ORDER_PART_FIRST  = 8'h01;

   // Header bytes following the opcode
   localparam logic [2:0] HDR_NONE       = 3'h0;
   localparam logic [2:0] HDR_ADDR       = 3'h3;
   localparam logic [2:0] HDR_ADDR_DUMMY = 3'h4;

   // Total byte counts at which a framed command may end, the byte index cap and the last bit index
   localparam logic [2:0] LEN_SINGLE     = 3'h1;
   localparam logic [2:0] LEN_STATE_WR   = 3'h2;
   localparam logic [2:0] LEN_ADDR_CMD   = 3'h4;
   localparam logic [2:0] LEN_PAGE_MIN   = 3'h5;
   localparam logic [2:0] BYTE_IDX_MAX   = 3'h7;
   localparam logic [2:0] BIT_LAST       = 3'h7;

   // Decoded command kinds, presented with the commit strobe
   typedef enum logic [4:0]
   {
      CMD_NONE, CMD_PERMIT_SET, CMD_PERMIT_CLR, CMD_STATE_WR, CMD_STATE_RD,
      CMD_READ, CMD_FAST_READ, CMD_READ_TWO, CMD_PARAM_READ, CMD_ID_TRIPLE,
      CMD_LEGACY_ID, CMD_MAKER_PART, CMD_SMALL_CLR, CMD_LARGE_CLR,
      CMD_WHOLE_CLR, CMD_PAGE_WRITE, CMD_SLEEP_ENTRY, CMD_SLEEP_EXIT
   } sfcd_cmd_t;

   // Decoder states within one chip-select frame
   typedef enum logic [2:0]
   {
      ST_IDLE, ST_OPCODE, ST_HEADER, ST_DATA, ST_OUT, ST_IGNORE
   } sfcd_state_t;

endpackage

// ### verilog/sfcd_sync.sv
// Two-stage synchroniser for the serial clock, chip select and data input.
// Assumes the pins are asynchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module sfcd_sync
#(
   parameter int WIDTH = 3
)
(
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_reset_n,
   // Raw pins: {sclk, cs_n, si}
   input  wire logic [WIDTH-1:0] i_pins,
   // Synchronised side
   sfcd_link_if.drive            lk
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // First stage feeds only the second; chip select idles high
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         stage1 <= WIDTH'(3'h2);
         stage2 <= WIDTH'(3'h2);
      end
      else
      begin
         stage1 <= i_pins;
         stage2 <= stage1;
      end
   end

   assign lk.sclk = stage2[2];
   assign lk.cs_n = stage2[1];
   assign lk.si   = stage2[0];

endmodule // sfcd_sync
`default_nettype wire

// ### verilog/sfcd_top.sv
// Command decoder for a serial NOR flash, with write-permit latch,
// status read and identification queries.
// Assumes program/erase engines report busy and a completion pulse on i_core_clk.
// Behaviour
// - Opcode 06h sets write-permit latch
// - Opcode 04h clears write-permit latch
// - Latch cleared after power-up
// - Status write 01h, latch cleared when done
// - Page write 02h, latch cleared when done
// - Small clear 20h, latch cleared when done
// - Large clear 52h/D8h, latch cleared when done
// - Whole clear 60h/C7h, latch cleared when done
// - Opcode 05h streams status byte
// - Status read always allowed, repeats live byte
// - 90h, two dummies, order byte, IDs out
// - Order 00h maker first, 01h part first
// - Framed commands rejected off byte boundary
// - Unknown opcode: quiet until next select
// - Modifying commands need latch set
// - Busy flag reflects running cycle
`timescale 1ns/10ps
`default_nettype none
module sfcd_top
#(
   parameter logic [7:0] MAKER_CODE   = 8'h5C, // Arbitrary value
   parameter logic [7:0] PART_CODE_HI = 8'h21, // Arbitrary value
   parameter logic [7:0] PART_CODE_LO = 8'h12, // Arbitrary value
   parameter logic [7:0] LEGACY_CODE  = 8'h11  // Arbitrary value
)
(
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_reset_n,
   // Serial pins
   input  wire logic              i_sclk,
   input  wire logic              i_cs_n,
   input  wire logic              i_si,
   output logic                   o_so,
   output logic                   o_so_oe,
   // Engine side
   input  wire logic              i_busy,
   input  wire logic              i_op_done,
   input  wire logic [5:0]        i_prot_bits,
   input  wire logic [7:0]        i_array_byte,
   output logic                   o_array_req,
   output logic                   o_cmd_go,
   output sfcd_pkg::sfcd_cmd_t    o_cmd,
   output logic [23:0]            o_addr,
   output logic                   o_data_valid,
   output logic [7:0]             o_data,
   output logic                   o_write_permit
);
   import sfcd_pkg::*;

   sfcd_link_if lk ();
   sfcd_state_t state;
   sfcd_cmd_t   cmd;
   sfcd_cmd_t   dec_cmd;
   logic        sclk_d;
   logic        cs_d;
   logic [2:0]  bit_cnt;
   logic [2:0]  byte_idx;
   logic [6:0]  shreg;
   logic [2:0]  obit;
   logic [1:0]  oidx;
   logic        part_first;
   logic        rst_seen;
   logic [2:0]  dec_hdr;
   logic [7:0]  byte_in;
   logic [7:0]  cur_byte;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        cs_rise;
   logic        byte_done;
   logic        is_output;
   logic        modifying;
   logic        commit_ok;
   logic        commit_set;
   logic        commit_clr;
   logic        hdr_last;

   sfcd_sync #(.WIDTH(3)) u_sync
   (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_pins     ({i_sclk, i_cs_n, i_si}),
      .lk         (lk.drive)
   );

   // Edge detection on already synchronised pins
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
      end
      else
      begin
         sclk_d <= lk.sclk;
         cs_d   <= lk.cs_n;
      end
   end

   assign sclk_rise = lk.sclk & ~sclk_d & ~lk.cs_n;
   assign sclk_fall = ~lk.sclk & sclk_d & ~lk.cs_n;
   assign cs_fall   = ~lk.cs_n & cs_d;
   assign cs_rise   = lk.cs_n & ~cs_d;
   assign byte_done = sclk_rise && (bit_cnt == BIT_LAST);
   assign byte_in   = {shreg, lk.si};

   // Opcode decode with header length
   always_comb
   begin
      dec_hdr = HDR_NONE;
      case (byte_in)
         OP_PERMIT_SET:  dec_cmd = CMD_PERMIT_SET;
         OP_PERMIT_CLR:  dec_cmd = CMD_PERMIT_CLR;
         OP_STATE_WR:    dec_cmd = CMD_STATE_WR;
         OP_STATE_RD:    dec_cmd = CMD_STATE_RD;
         OP_ID_TRIPLE:   dec_cmd = CMD_ID_TRIPLE;
         OP_SLEEP_ENTRY: dec_cmd = CMD_SLEEP_ENTRY;
         OP_WHOLE_CLR_A,
         OP_WHOLE_CLR_B: dec_cmd = CMD_WHOLE_CLR;
         OP_READ:        begin dec_cmd = CMD_READ;       dec_hdr = HDR_ADDR;       end
         OP_FAST_READ:   begin dec_cmd = CMD_FAST_READ;  dec_hdr = HDR_ADDR_DUMMY; end
         OP_READ_TWO:    begin dec_cmd = CMD_READ_TWO;   dec_hdr = HDR_ADDR_DUMMY; end
         OP_PARAM_READ:  begin dec_cmd = CMD_PARAM_READ; dec_hdr = HDR_ADDR_DUMMY; end
         OP_LEGACY_ID:   begin dec_cmd = CMD_LEGACY_ID;  dec_hdr = HDR_ADDR;       end
         OP_MAKER_PART:  begin dec_cmd = CMD_MAKER_PART; dec_hdr = HDR_ADDR;       end
         OP_SMALL_CLR:   begin dec_cmd = CMD_SMALL_CLR;  dec_hdr = HDR_ADDR;       end
         OP_LARGE_CLR_A,
         OP_LARGE_CLR_B: begin dec_cmd = CMD_LARGE_CLR;  dec_hdr = HDR_ADDR;       end
         OP_PAGE_WRITE:  begin dec_cmd = CMD_PAGE_WRITE; dec_hdr = HDR_ADDR;       end
         default:        dec_cmd = CMD_NONE;
      endcase
   end

   assign modifying = (dec_cmd == CMD_STATE_WR) || (dec_cmd == CMD_PAGE_WRITE) ||
                      (dec_cmd == CMD_SMALL_CLR) || (dec_cmd == CMD_LARGE_CLR) ||
                      (dec_cmd == CMD_WHOLE_CLR);
   assign is_output = (cmd == CMD_STATE_RD) || (cmd == CMD_ID_TRIPLE) || (cmd == CMD_READ) ||
                      (cmd == CMD_FAST_READ) || (cmd == CMD_READ_TWO) || (cmd == CMD_PARAM_READ) ||
                      (cmd == CMD_LEGACY_ID) || (cmd == CMD_MAKER_PART);

   // Last header byte; reads with a dummy run one byte past the address
   assign hdr_last  = byte_idx == ((cmd == CMD_FAST_READ || cmd == CMD_READ_TWO || cmd == CMD_PARAM_READ) ?
                                   HDR_ADDR_DUMMY : HDR_ADDR);

   // Frame sequencing, bit and byte counting
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state    <= ST_IDLE;
         cmd      <= CMD_NONE;
         bit_cnt  <= 3'h0;
         byte_idx <= 3'h0;
         shreg    <= 7'h00;
      end
      else if (cs_fall)
      begin
         state    <= ST_OPCODE;
         bit_cnt  <= 3'h0;
         byte_idx <= 3'h0;
      end
      else if (lk.cs_n)
         state <= ST_IDLE;
      else if (sclk_rise && state != ST_OUT && state != ST_IGNORE && state != ST_IDLE)
      begin
         bit_cnt <= bit_cnt + 3'h1;
         shreg   <= byte_in[6:0];
         if (bit_cnt == BIT_LAST)
         begin
            if (byte_idx != BYTE_IDX_MAX)
               byte_idx <= byte_idx + 3'h1;
            if (state == ST_OPCODE)
            begin
               cmd <= dec_cmd;
               // Undefined opcodes and unpermitted writes go quiet till next select
               if (dec_cmd == CMD_NONE || (modifying && (!o_write_permit || i_busy)))
                  state <= ST_IGNORE;
               else if (dec_hdr != HDR_NONE)
                  state <= ST_HEADER;
               else if (dec_cmd == CMD_STATE_RD || dec_cmd == CMD_ID_TRIPLE)
                  state <= ST_OUT;
               else
                  state <= ST_DATA;
            end
            else if (state == ST_HEADER)
            begin
               if (hdr_last)
                  state <= is_output ? ST_OUT : ST_DATA;
            end
         end
      end
   end

   // Address capture, order select and incoming data bytes
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_addr       <= 24'h000000;
         part_first   <= 1'b0;
         o_data       <= 8'h00;
         o_data_valid <= 1'b0;
      end
      else
      begin
         o_data_valid <= 1'b0;
         if (byte_done && state == ST_HEADER && byte_idx <= 3'h3)
         begin
            o_addr <= {o_addr[15:0], byte_in};
            if (byte_idx == 3'h3 && cmd == CMD_MAKER_PART)
               part_first <= (byte_in == ORDER_PART_FIRST);
         end
         if (byte_done && state == ST_DATA)
         begin
            o_data       <= byte_in;
            o_data_valid <= 1'b1;
         end
      end
   end

   // Byte presented on the output lane; status is live so busy can be polled
   always_comb
   begin
      case (cmd)
         CMD_STATE_RD:   cur_byte = {i_prot_bits, o_write_permit, i_busy};
         CMD_ID_TRIPLE:  cur_byte = (oidx == 2'h0) ? MAKER_CODE :
                                    (oidx == 2'h1) ? PART_CODE_HI : PART_CODE_LO;
         CMD_MAKER_PART: cur_byte = (oidx[0] ^ part_first) ? PART_CODE_LO : MAKER_CODE;
         CMD_LEGACY_ID:  cur_byte = LEGACY_CODE;
         default:        cur_byte = i_array_byte;
      endcase
   end

   // Shift out on falling clock; array asked for a byte ahead of its use
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_so        <= 1'b0;
         obit        <= 3'h0;
         oidx        <= 2'h0;
         o_array_req <= 1'b0;
      end
      else
      begin
         // The last header byte and the end of each streamed byte ask, so the datapath advances once per byte
         o_array_req <= byte_done && state == ST_HEADER && hdr_last && is_output;
         if (state != ST_OUT)
         begin
            obit <= 3'h0;
            oidx <= 2'h0;
         end
         else if (sclk_fall)
         begin
            o_so <= cur_byte[3'h7 - obit];
            obit <= obit + 3'h1;
            if (obit == BIT_LAST)
            begin
               oidx        <= (cmd == CMD_ID_TRIPLE && oidx == 2'h2) ? 2'h0 : oidx + 2'h1;
               o_array_req <= 1'b1;
            end
         end
      end
   end

   // Lane driven only while streaming inside a selected frame
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_so_oe <= 1'b0;
      else
         o_so_oe <= state == ST_OUT && !lk.cs_n && !cs_rise;
   end

   // Framed commands commit only on an exact byte boundary
   always_comb
   begin
      commit_ok = 1'b0;
      if (bit_cnt == 3'h0 && (state == ST_DATA || state == ST_HEADER))
      begin
         case (cmd)
            CMD_PERMIT_SET, CMD_PERMIT_CLR,
            CMD_WHOLE_CLR, CMD_SLEEP_ENTRY,
            CMD_LEGACY_ID:                commit_ok = (byte_idx == LEN_SINGLE);
            CMD_STATE_WR:                 commit_ok = (byte_idx == LEN_STATE_WR);
            CMD_SMALL_CLR, CMD_LARGE_CLR: commit_ok = (byte_idx == LEN_ADDR_CMD);
            CMD_PAGE_WRITE:               commit_ok = (byte_idx >= LEN_PAGE_MIN);
            default:                      commit_ok = 1'b0;
         endcase
      end
   end

   assign commit_set = cs_rise && commit_ok && cmd == CMD_PERMIT_SET;
   assign commit_clr = cs_rise && commit_ok && cmd == CMD_PERMIT_CLR;

   // Command strobe to the engines; ABh ended after its opcode is a sleep exit
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_cmd_go <= 1'b0;
         o_cmd    <= CMD_NONE;
      end
      else
      begin
         o_cmd_go <= cs_rise && commit_ok;
         if (cs_rise && commit_ok)
            o_cmd <= (cmd == CMD_LEGACY_ID) ? CMD_SLEEP_EXIT : cmd;
      end
   end

   // Write-permit latch; a set in the same cycle as a completion wins
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_write_permit <= 1'b0;
      else if (commit_set)
         o_write_permit <= 1'b1;
      else if (commit_clr || i_op_done)
         o_write_permit <= 1'b0;
   end

   // Marks the first cycle after reset release
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rst_seen <= 1'b0;
      else
         rst_seen <= 1'b1;
   end

   chk_permit_set_latch: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      commit_set |=> o_write_permit) else $error("permit set not latched");
   chk_permit_clr_latch: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      commit_clr |=> !o_write_permit) else $error("permit clear not latched");
   chk_permit_power_up: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      !rst_seen |-> !o_write_permit) else $error("permit set after reset");
   chk_done_clears_permit: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_op_done && !commit_set) |=> !o_write_permit) else $error("permit kept after completion");
   chk_go_on_boundary: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      o_cmd_go |-> $past(cs_rise) && $past(bit_cnt) == 3'h0)
      else $error("command committed off boundary");
   chk_permit_gates_write: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (byte_done && state == ST_OPCODE && modifying && !o_write_permit) |=> state == ST_IGNORE)
      else $error("write accepted without permit");
   chk_unknown_quiet: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state == ST_IGNORE) |=> !o_so_oe) else $error("lane driven after unknown opcode");
   chk_status_busy_bit: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (state == ST_OUT && cmd == CMD_STATE_RD && sclk_fall && obit == BIT_LAST)
      |=> o_so == $past(i_busy)) else $error("busy bit wrong in status");
   chk_deselect_quiet: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      lk.cs_n |=> !o_so_oe) else $error("lane driven while deselected");

endmodule // sfcd_top
`default_nettype wire
